// File: rtl/amd_params.svh
// named constants of the addressing-mode decoder
// assumes inclusion by the package and the decoder; guarded against repeats
`ifndef AMD_PARAMS_SVH
`define AMD_PARAMS_SVH

// data and address widths
`define AMD_BYTE_W 8
`define AMD_ADDR_W 16
`define AMD_LEN_W 2
`define AMD_SIGN_BIT 7
`define AMD_ZERO_PAGE 8'h00
`define AMD_ONE 16'h0001

// operand byte counts after the opcode
`define AMD_LEN_0 2'h0
`define AMD_LEN_1 2'h1
`define AMD_LEN_2 2'h2

// interrupt mask levels
`define AMD_MASK_W 2
`define AMD_MASK_HI 2'h3
`define AMD_MASK_LO 2'h0

// state codes, gray in the order listed here
`define AMD_ST_IDLE 3'h0
`define AMD_ST_OPND1 3'h1
`define AMD_ST_OPND2 3'h3
`define AMD_ST_PTRHI 3'h2
`define AMD_ST_PTRLO 3'h6
`define AMD_ST_FIN 3'h4

// addressing mode codes
`define AMD_M_INH 4'h0
`define AMD_M_IMM 4'h1
`define AMD_M_DIR_S 4'h2
`define AMD_M_DIR_L 4'h3
`define AMD_M_IDX_0 4'h4
`define AMD_M_IDX_S 4'h5
`define AMD_M_IDX_L 4'h6
`define AMD_M_IND_S 4'h7
`define AMD_M_IND_L 4'h8
`define AMD_M_IIX_S 4'h9
`define AMD_M_IIX_L 4'hA
`define AMD_M_REL_D 4'hB
`define AMD_M_REL_I 4'hC

// special inherent kinds
`define AMD_K_NONE 3'h0
`define AMD_K_MASK_RAISE 3'h1
`define AMD_K_MASK_LOWER 3'h2
`define AMD_K_HALT 3'h3
`define AMD_K_WAIT 3'h4

`endif

// File: rtl/amd_pkg.sv
// types shared by the addressing-mode decoder and its bench
// assumes amd_params.svh is on the include path
`include "amd_params.svh"
`default_nettype none

package amd_pkg;

  // ****************************************
  // enumerations
  // ****************************************
  typedef enum logic [3:0] {
    AMD_INH = `AMD_M_INH, AMD_IMM = `AMD_M_IMM,
    AMD_DIR_S = `AMD_M_DIR_S, AMD_DIR_L = `AMD_M_DIR_L,
    AMD_IDX_0 = `AMD_M_IDX_0, AMD_IDX_S = `AMD_M_IDX_S, AMD_IDX_L = `AMD_M_IDX_L,
    AMD_IND_S = `AMD_M_IND_S, AMD_IND_L = `AMD_M_IND_L,
    AMD_IIX_S = `AMD_M_IIX_S, AMD_IIX_L = `AMD_M_IIX_L,
    AMD_REL_D = `AMD_M_REL_D, AMD_REL_I = `AMD_M_REL_I
  } amd_mode_t;

  typedef enum logic [2:0] {
    AMD_K_NONE = `AMD_K_NONE, mask_raise_instr = `AMD_K_MASK_RAISE,
    mask_lower_instr = `AMD_K_MASK_LOWER, AMD_K_HALT = `AMD_K_HALT,
    wait_for_irq_instr = `AMD_K_WAIT
  } amd_kind_t;

  typedef enum logic [2:0] {
    AMD_ST_IDLE = `AMD_ST_IDLE, AMD_ST_OPND1 = `AMD_ST_OPND1,
    AMD_ST_OPND2 = `AMD_ST_OPND2, AMD_ST_PTRHI = `AMD_ST_PTRHI,
    AMD_ST_PTRLO = `AMD_ST_PTRLO, AMD_ST_FIN = `AMD_ST_FIN
  } amd_state_t;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    amd_mode_t mode;
    amd_kind_t kind;
    logic sel_y;
    logic rmw;
  } amd_req_t;

  typedef struct packed {
    logic [`AMD_ADDR_W-1:0] ea;
    logic [`AMD_BYTE_W-1:0] imm;
    logic [`AMD_ADDR_W-1:0] seq_pc;
    logic [`AMD_ADDR_W-1:0] branch_pc;
    logic [`AMD_LEN_W-1:0] len;
    logic has_ea;
    logic has_imm;
    logic has_branch;
    logic illegal;
  } amd_res_t;

endpackage

`default_nettype wire

// File: rtl/amd_decoder.sv
// addressing-mode decoder: operand fetch and effective-address forming
// assumes a same-clock byte memory port with a req/ack handshake and
// that the opcode's mode and kind arrive decoded with start_i
// halt and wait are left only by irq_i or by reset
// How it works
// - inherent instructions are one byte only
// - immediate: second byte is the operand value
// - short direct: one byte, page zero
// - long direct: two-byte word address, full space
// - indexed: unsigned sum index plus offset
// - no offset: index alone, no byte
// - short indexed: nine-bit sum up to 1FE
// - long indexed: word offset plus index
// - indirect: fetch operand address at pointer
// - short indirect: byte pointer, page zero
// - long indirect forms fetch a word pointer
// - indirect indexed: pointer value plus index
// - short indirect indexed reaches up to 1FE
// - relative: sequential pc plus signed byte offset
// - relative direct: offset follows the opcode
// - relative indirect: offset read from memory
// - mask raise sets 3, lower sets 0
// - halt and wait both hold off new starts until interrupt
// - read-modify-write instructions: short forms only
`include "amd_params.svh"
`default_nettype none

module amd_decoder
  import amd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire amd_req_t req_i,
  input wire logic [`AMD_ADDR_W-1:0] pc_i,
  input wire logic [`AMD_BYTE_W-1:0] idx_x_i,
  input wire logic [`AMD_BYTE_W-1:0] idx_y_i,
  input wire logic irq_i,
  output logic ready_o,
  output logic mem_req_o,
  output logic [`AMD_ADDR_W-1:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic [`AMD_BYTE_W-1:0] mem_rdata_i,
  output logic done_o,
  output amd_res_t res_o,
  output logic [`AMD_MASK_W-1:0] irq_mask_o,
  output logic halt_o,
  output logic wait_o
);

  // ****************************************
  // helpers
  // ****************************************

  // operand bytes following the opcode
  function automatic logic [`AMD_LEN_W-1:0] mode_len(input amd_mode_t m);
    case (m)
      AMD_INH, AMD_IDX_0: mode_len = `AMD_LEN_0;
      AMD_DIR_L, AMD_IDX_L: mode_len = `AMD_LEN_2;
      default: mode_len = `AMD_LEN_1;
    endcase
  endfunction

  // long forms reach beyond page zero
  function automatic logic is_long(input amd_mode_t m);
    case (m)
      AMD_DIR_L, AMD_IDX_L, AMD_IND_L, AMD_IIX_L: is_long = 1'b1;
      default: is_long = 1'b0;
    endcase
  endfunction

  // zero-extend a byte to an address
  function automatic logic [`AMD_ADDR_W-1:0] zext(input logic [`AMD_BYTE_W-1:0] b);
    zext = {`AMD_ZERO_PAGE, b};
  endfunction

  // sign-extend a relative offset
  function automatic logic [`AMD_ADDR_W-1:0] sext(input logic [`AMD_BYTE_W-1:0] b);
    sext = {{`AMD_BYTE_W{b[`AMD_SIGN_BIT]}}, b};
  endfunction

  // ****************************************
  // sequencer state
  // ****************************************
  amd_state_t state_r, state_nxt;
  amd_req_t req_r, req_nxt;
  amd_res_t res_r, res_nxt;
  logic [`AMD_ADDR_W-1:0] addr_r, addr_nxt;
  // only the chosen index is kept, so the other may change freely
  logic [`AMD_BYTE_W-1:0] idx_r, idx_nxt;
  logic [`AMD_BYTE_W-1:0] hi_r, hi_nxt;
  logic [`AMD_MASK_W-1:0] mask_r, mask_nxt;
  logic halt_r, halt_nxt;
  logic wait_r, wait_nxt;
  logic [`AMD_ADDR_W-1:0] word_w;
  logic [`AMD_ADDR_W-1:0] idx_w;

  // ****************************************
  // handshake outputs
  // ****************************************

  // new instructions are held off while stopped or busy
  assign ready_o = (state_r == AMD_ST_IDLE) && !halt_r && !wait_r;
  assign mem_req_o = (state_r == AMD_ST_OPND1) || (state_r == AMD_ST_OPND2)
                     || (state_r == AMD_ST_PTRHI) || (state_r == AMD_ST_PTRLO);
  assign done_o = (state_r == AMD_ST_FIN);
  assign mem_addr_o = addr_r;
  assign res_o = res_r;
  assign irq_mask_o = mask_r;
  assign halt_o = halt_r;
  assign wait_o = wait_r;

  // high byte came first, this byte is the low one
  assign word_w = {hi_r, mem_rdata_i};
  assign idx_w = zext(idx_r);

  // ****************************************
  // next-state of the sequencer
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    req_nxt = req_r;
    res_nxt = res_r;
    addr_nxt = addr_r;
    idx_nxt = idx_r;
    hi_nxt = hi_r;
    case (state_r)
      AMD_ST_IDLE: begin
        if (start_i && ready_o) begin
          req_nxt = req_i;
          idx_nxt = req_i.sel_y ? idx_y_i : idx_x_i;
          res_nxt = '0;
          res_nxt.len = mode_len(req_i.mode);
          // sequential pc skips opcode and operands
          res_nxt.seq_pc = pc_i + `AMD_ONE + zext({6'h00, mode_len(req_i.mode)});
          // long forms flagged when rmw, result still formed
          res_nxt.illegal = req_i.rmw && is_long(req_i.mode);
          // operand bytes start right after the opcode
          addr_nxt = pc_i + `AMD_ONE;
          case (req_i.mode)
            AMD_INH: state_nxt = AMD_ST_FIN;
            AMD_IDX_0: begin
              res_nxt.ea = zext(req_i.sel_y ? idx_y_i : idx_x_i);
              res_nxt.has_ea = 1'b1;
              state_nxt = AMD_ST_FIN;
            end
            default: state_nxt = AMD_ST_OPND1;
          endcase
        end
      end
      AMD_ST_OPND1: begin
        if (mem_ack_i) begin
          hi_nxt = mem_rdata_i;
          state_nxt = AMD_ST_FIN;
          case (req_r.mode)
            AMD_IMM: begin
              res_nxt.imm = mem_rdata_i;
              res_nxt.has_imm = 1'b1;
            end
            AMD_DIR_S: begin
              res_nxt.ea = zext(mem_rdata_i);
              res_nxt.has_ea = 1'b1;
            end
            AMD_IDX_S: begin
              // nine-bit sum kept, never wrapped to a byte
              res_nxt.ea = zext(mem_rdata_i) + idx_w;
              res_nxt.has_ea = 1'b1;
            end
            AMD_DIR_L, AMD_IDX_L: begin
              addr_nxt = addr_r + `AMD_ONE;
              state_nxt = AMD_ST_OPND2;
            end
            AMD_REL_D: begin
              res_nxt.branch_pc = res_r.seq_pc + sext(mem_rdata_i);
              res_nxt.has_branch = 1'b1;
            end
            default: begin
              // codes beyond the relative ones also take this pointer path
              // pointer address is always in page zero
              addr_nxt = zext(mem_rdata_i);
              state_nxt = AMD_ST_PTRHI;
            end
          endcase
        end
      end
      AMD_ST_OPND2: begin
        if (mem_ack_i) begin
          res_nxt.has_ea = 1'b1;
          state_nxt = AMD_ST_FIN;
          // this byte is the low half of the word
          if (req_r.mode == AMD_IDX_L) begin
            res_nxt.ea = word_w + idx_w;
          end else begin
            res_nxt.ea = word_w;
          end
        end
      end
      AMD_ST_PTRHI: begin
        if (mem_ack_i) begin
          hi_nxt = mem_rdata_i;
          state_nxt = AMD_ST_FIN;
          case (req_r.mode)
            AMD_IND_S: begin
              res_nxt.ea = zext(mem_rdata_i);
              res_nxt.has_ea = 1'b1;
            end
            AMD_IIX_S: begin
              res_nxt.ea = zext(mem_rdata_i) + idx_w;
              res_nxt.has_ea = 1'b1;
            end
            AMD_REL_I: begin
              res_nxt.branch_pc = res_r.seq_pc + sext(mem_rdata_i);
              res_nxt.has_branch = 1'b1;
            end
            default: begin
              // word pointer may straddle into page one
              addr_nxt = addr_r + `AMD_ONE;
              state_nxt = AMD_ST_PTRLO;
            end
          endcase
        end
      end
      AMD_ST_PTRLO: begin
        if (mem_ack_i) begin
          res_nxt.has_ea = 1'b1;
          state_nxt = AMD_ST_FIN;
          // low pointer byte completes the word pointer
          if (req_r.mode == AMD_IIX_L) begin
            res_nxt.ea = word_w + idx_w;
          end else begin
            res_nxt.ea = word_w;
          end
        end
      end
      // one-cycle strobe; res_r holds until the next accepted start
      AMD_ST_FIN: state_nxt = AMD_ST_IDLE;
      default: state_nxt = AMD_ST_IDLE;
    endcase
  end

  // ****************************************
  // sequencer registers
  // ****************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= AMD_ST_IDLE;
      req_r <= '0;
      res_r <= '0;
      addr_r <= '0;
      idx_r <= '0;
      hi_r <= '0;
    end else begin
      state_r <= state_nxt;
      req_r <= req_nxt;
      res_r <= res_nxt;
      addr_r <= addr_nxt;
      idx_r <= idx_nxt;
      hi_r <= hi_nxt;
    end
  end

  // ****************************************
  // mask level and power state
  // ****************************************

  // wake first, then set, so a stop issued as an interrupt lands is kept
  always_comb begin
    mask_nxt = mask_r;
    halt_nxt = halt_r;
    wait_nxt = wait_r;
    if (irq_i) begin
      halt_nxt = 1'b0;
      wait_nxt = 1'b0;
    end
    // kind acts once, in the strobe cycle
    if (state_r == AMD_ST_FIN) begin
      case (req_r.kind)
        mask_raise_instr: mask_nxt = `AMD_MASK_HI;
        mask_lower_instr: mask_nxt = `AMD_MASK_LO;
        AMD_K_HALT: halt_nxt = 1'b1;
        wait_for_irq_instr: wait_nxt = 1'b1;
        default: mask_nxt = mask_r;
      endcase
    end
  end

  // mask comes up fully raised, as after a reset
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask_r <= `AMD_MASK_HI;
      halt_r <= 1'b0;
      wait_r <= 1'b0;
    end else begin
      mask_r <= mask_nxt;
      halt_r <= halt_nxt;
      wait_r <= wait_nxt;
    end
  end

endmodule

`default_nettype wire

// File: verif/amd_decoder_asserts.sv
// checker for the addressing-mode decoder, watching its ports only
// assumes one clock domain and bind from the bench top file
`include "amd_params.svh"
`default_nettype none

module amd_decoder_asserts
  import amd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire amd_req_t req_i,
  input wire logic [`AMD_ADDR_W-1:0] pc_i,
  input wire logic [`AMD_BYTE_W-1:0] idx_x_i,
  input wire logic [`AMD_BYTE_W-1:0] idx_y_i,
  input wire logic irq_i,
  input wire logic ready_o,
  input wire logic mem_req_o,
  input wire logic [`AMD_ADDR_W-1:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic [`AMD_BYTE_W-1:0] mem_rdata_i,
  input wire logic done_o,
  input wire amd_res_t res_o,
  input wire logic [`AMD_MASK_W-1:0] irq_mask_o,
  input wire logic halt_o,
  input wire logic wait_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic [15:0] pc_q;
  amd_mode_t mode_q;
  amd_kind_t kind_q;
  logic take;
  // ****************************************
  // helper: what the accepted start asked for
  // ****************************************
  assign take = start_i && ready_o;
  // kept until the next accepted start, so done can be tied to its cause
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pc_q <= 16'h0000;
      mode_q <= AMD_INH;
      kind_q <= AMD_K_NONE;
    end else if (take) begin
      pc_q <= pc_i;
      mode_q <= req_i.mode;
      kind_q <= req_i.kind;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  a_inh_single: assert property (take && req_i.mode == AMD_INH |=> done_o && !mem_req_o)
    else $error("inherent decode not one cycle");
  a_idx0_index: assert property (take && req_i.mode == AMD_IDX_0 |=> done_o &&
    res_o.ea == {8'h00, ($past(req_i.sel_y) ? $past(idx_y_i) : $past(idx_x_i))})
    else $error("no-offset index address wrong");
  a_first_fetch: assert property (take && !(req_i.mode inside {AMD_INH, AMD_IDX_0}) |=>
    mem_req_o && mem_addr_o == pc_q + 16'h0001)
    else $error("first operand fetch address wrong");
  a_addr_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
    else $error("fetch request dropped before answer");
  a_seq_pc: assert property (done_o |-> res_o.seq_pc == pc_q + 16'h0001 + {14'h0, res_o.len})
    else $error("sequential pc does not match length");
  a_short_page: assert property (done_o &&
    mode_q inside {AMD_DIR_S, AMD_IND_S, AMD_IDX_0} |-> res_o.ea[15:8] == 8'h00)
    else $error("short address left page zero");
  a_short_sum: assert property (done_o &&
    mode_q inside {AMD_IDX_S, AMD_IIX_S} |-> res_o.ea <= 16'h01FE)
    else $error("short indexed sum out of range");
  a_mask_set: assert property (done_o && kind_q == mask_raise_instr |=> irq_mask_o == 2'h3)
    else $error("mask not raised");
  a_mask_clr: assert property (done_o && kind_q == mask_lower_instr |=> irq_mask_o == 2'h0)
    else $error("mask not lowered");
  a_halt_enter: assert property (done_o && kind_q == AMD_K_HALT |=> halt_o && !ready_o)
    else $error("halt not entered");
  a_wake_irq: assert property ((halt_o || wait_o) && irq_i && !done_o |=> !halt_o && !wait_o)
    else $error("interrupt did not wake");
  // ****************************************
  // covers
  // ****************************************
  c_ind_long: cover property (done_o && mode_q == AMD_IND_L);
  c_mem_stall: cover property (mem_req_o && !mem_ack_i);
  c_wait: cover property ($rose(wait_o));
endmodule

`default_nettype wire

// File: verif/amd_mem_model.sv
// behavioural program and data memory answering the decoder's fetches
// assumes same-clock req/ack; latency chosen by the bench once per decode, shared by its transfers
`default_nettype none

module amd_mem_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic mem_req_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic [1:0] lat_i,
  output logic mem_ack_o,
  output logic [7:0] mem_rdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] cnt_r;
  logic [7:0] noise_r;
  // memory contents as a pure function of the address
  function automatic logic [7:0] byte_at(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  // data only valid with ack; otherwise a changing pattern
  assign mem_ack_o = mem_req_i && (cnt_r == lat_i);
  assign mem_rdata_o = mem_ack_o ? byte_at(mem_addr_i) : noise_r;
  // wait counter and noise source
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= 2'h0;
      noise_r <= 8'hA5;
    end else begin
      cnt_r <= (mem_req_i && !mem_ack_o) ? cnt_r + 2'h1 : 2'h0;
      noise_r <= {noise_r[6:0], ~noise_r[7]};
    end
  end
endmodule

`default_nettype wire

// File: verif/tb_amd_decoder.sv
// self-checking bench for the addressing-mode decoder
// assumes amd_pkg, the memory model and the checker are compiled first
`include "amd_params.svh"
`default_nettype none

module tb_amd_decoder;
  import amd_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i, rstn_i = 1'b0, start_i = 1'b0, irq_i = 1'b0;
  amd_req_t req_i = '0;
  logic [15:0] pc_i = 16'h0000, mem_addr_o;
  logic [7:0] idx_x_i = 8'h00, idx_y_i = 8'h00, mem_rdata_i;
  logic ready_o, mem_req_o, mem_ack_i, done_o, halt_o, wait_o;
  logic [1:0] irq_mask_o, lat = 2'h0, exp_mask = 2'h3;
  amd_res_t res_o;
  amd_res_t exp_q[$];
  amd_kind_t kinds[6] = '{mask_lower_instr, AMD_K_HALT, mask_raise_instr, wait_for_irq_instr,
    mask_lower_instr, AMD_K_NONE};
  int bad_count = 0, tests_run = 0;
  // ****************************************
  // clock, design and partner
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  amd_decoder i_amd_decoder (.clk_i(clk_i), .rstn_i(rstn_i), .start_i(start_i), .req_i(req_i),
    .pc_i(pc_i), .idx_x_i(idx_x_i), .idx_y_i(idx_y_i), .irq_i(irq_i), .ready_o(ready_o),
    .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i), .done_o(done_o), .res_o(res_o), .irq_mask_o(irq_mask_o),
    .halt_o(halt_o), .wait_o(wait_o));
  amd_mem_model i_amd_mem_model (.clk_i(clk_i), .rstn_i(rstn_i), .mem_req_i(mem_req_o),
    .mem_addr_i(mem_addr_o), .lat_i(lat), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
  // ****************************************
  // checking and verdict
  // ****************************************
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // expected result from memory contents, index and mode
  function automatic amd_res_t exp_res(amd_mode_t m, logic [15:0] pc, logic [7:0] ix, logic rw);
    logic [7:0] b1, b2, p1, p2, o;
    amd_res_t r;
    b1 = i_amd_mem_model.byte_at(pc + 16'h0001);
    b2 = i_amd_mem_model.byte_at(pc + 16'h0002);
    p1 = i_amd_mem_model.byte_at({8'h00, b1});
    p2 = i_amd_mem_model.byte_at({8'h00, b1} + 16'h0001);
    o = (m == AMD_REL_D) ? b1 : p1;
    r = '0;
    r.len = 2'h1;
    r.has_ea = 1'b1;
    case (m)
      AMD_INH: begin r.len = 2'h0; r.has_ea = 1'b0; end
      AMD_IMM: begin r.has_ea = 1'b0; r.has_imm = 1'b1; r.imm = b1; end
      AMD_DIR_S: r.ea = {8'h00, b1};
      AMD_DIR_L: begin r.len = 2'h2; r.ea = {b1, b2}; end
      AMD_IDX_0: begin r.len = 2'h0; r.ea = {8'h00, ix}; end
      AMD_IDX_S: r.ea = {8'h00, b1} + {8'h00, ix};
      AMD_IDX_L: begin r.len = 2'h2; r.ea = {b1, b2} + {8'h00, ix}; end
      AMD_IND_S: r.ea = {8'h00, p1};
      AMD_IND_L: r.ea = {p1, p2};
      AMD_IIX_S: r.ea = {8'h00, p1} + {8'h00, ix};
      AMD_IIX_L: r.ea = {p1, p2} + {8'h00, ix};
      default: begin
        r.has_ea = 1'b0;
        r.has_branch = 1'b1;
        r.branch_pc = pc + 16'h0002 + {{8{o[7]}}, o};
      end
    endcase
    r.seq_pc = pc + 16'h0001 + {14'h0, r.len};
    r.illegal = rw && (m inside {AMD_DIR_L, AMD_IDX_L, AMD_IND_L, AMD_IIX_L});
    return r;
  endfunction
  // one decode: one-cycle start pulse, wait for done, then power side effects
  task automatic run(input amd_mode_t m, input amd_kind_t k, input logic [15:0] pc,
    input logic [7:0] ix);
    logic sel, rw;
    int n;
    sel = 1'($urandom);
    rw = 1'($urandom);
    n = 0;
    while (ready_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    lat = 2'($urandom_range(2));
    req_i = '{mode: m, kind: k, sel_y: sel, rmw: rw};
    pc_i = pc;
    idx_x_i = sel ? 8'($urandom) : ix;
    idx_y_i = sel ? ix : 8'($urandom);
    start_i = 1'b1;
    exp_q.push_back(exp_res(m, pc, ix, rw));
    @(posedge clk_i); #1;
    // start is a one-cycle pulse, dropped right after the taking edge
    start_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check("done", done_o, 1);
    @(posedge clk_i); #1;
    if (k == mask_raise_instr) exp_mask = 2'h3;
    if (k == mask_lower_instr) exp_mask = 2'h0;
    check("mask", irq_mask_o, exp_mask);
    check("halt", halt_o, k == AMD_K_HALT);
    check("wait", wait_o, k == wait_for_irq_instr);
    if (halt_o === 1'b1 || wait_o === 1'b1) begin
      irq_i = 1'b1;
      @(posedge clk_i); #1;
      irq_i = 1'b0;
      check("wake", {halt_o, wait_o, ready_o}, 3'b001);
    end
  endtask
  // ****************************************
  // result monitor
  // ****************************************
  always @(negedge clk_i) begin
    if (rstn_i === 1'b1 && done_o === 1'b1) begin
      if (exp_q.size() == 0) check("extra done", 1, 0);
      else check("result", res_o, exp_q.pop_front());
    end
  end
  // ****************************************
  // stimulus and watchdog
  // ****************************************
  initial begin
    void'($urandom(55));
    repeat (16) @(posedge clk_i);
    #1;
    rstn_i = 1'b1;
    // first pass: operand byte FF, index FF, word pointer wraps into page one
    for (int i = 0; i < 65; i++) begin
      run(amd_mode_t'(i % 13), AMD_K_NONE, (i < 13) ? 16'h00A4 : 16'($urandom),
        (i < 13) ? 8'hFF : 8'($urandom));
    end
    foreach (kinds[j]) run(AMD_INH, kinds[j], 16'($urandom), 8'($urandom));
    // mid-run reset: mask back to fully raised, decode path idle
    rstn_i = 1'b0;
    @(posedge clk_i); #1;
    check("reset outputs", {ready_o, mem_req_o, done_o, halt_o, wait_o, irq_mask_o}, 7'h43);
    check("reset result", res_o, 64'h0);
    rstn_i = 1'b1;
    exp_mask = 2'h3;
    // first start right at the edge after release
    run(AMD_IIX_L, AMD_K_NONE, 16'($urandom), 8'($urandom));
    check("pending", exp_q.size(), 0);
    print_verdict();
  end
  // run lasts well under this span
  initial begin
    #(4 * 40000);
    check("watchdog", 1, 0);
    print_verdict();
  end
endmodule

bind amd_decoder amd_decoder_asserts i_amd_decoder_asserts (.clk_i(clk_i), .rstn_i(rstn_i),
  .start_i(start_i), .req_i(req_i), .pc_i(pc_i), .idx_x_i(idx_x_i), .idx_y_i(idx_y_i),
  .irq_i(irq_i), .ready_o(ready_o), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o),
  .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .done_o(done_o), .res_o(res_o),
  .irq_mask_o(irq_mask_o), .halt_o(halt_o), .wait_o(wait_o));

`default_nettype wire
